// ==== src/eip_params.svh ====
// Constants for the external interrupt pin logic: offsets, fields, resets
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH
`define EIP_CFG_ADDR 8'hE4
`define EIP_CFG_RESET 8'h01
`define EIP_FIELD_STRIDE 4
`define EIP_POL_OFS 3
`define EIP_SEL_WIDTH 3
`define EIP_PEND0_BIT 1
`define EIP_PEND1_BIT 3
`define EIP_SYNC_RESET 8'hFF
`define EIP_RDATA_IDLE 8'h00
`endif

// ==== src/eip_pkg.sv ====
// Types shared by the external interrupt pin logic
package eip_pkg;
  typedef logic [2:0] eip_pin_sel_t;
  typedef enum logic {
    EIP_LEVEL = 1'b0,
    EIP_EDGE = 1'b1
  } eip_trig_e;
  typedef enum logic {
    EIP_ACT_LOW = 1'b0,
    EIP_ACT_HIGH = 1'b1
  } eip_pol_e;
endpackage : eip_pkg

// ==== src/eip_input_det.sv ====
// Per-input pin selection, polarity correction and pending-flag next value
`timescale 1ns/1ps
`default_nettype none
module eip_input_det
  import eip_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] pins_sync_in,
  input wire eip_pin_sel_t sel_in,
  input wire logic pol_in,
  input wire logic trig_in,
  input wire logic ack_in,
  input wire logic pend_in,
  output logic active_out,
  output logic pend_next_out
);
  logic prev_active_reg;
  logic rise;

  // Pick the monitored pin and fold in polarity
  always_comb begin
    active_out = (pins_sync_in[sel_in] == pol_in); // R1 R4 R5 R6
    rise = active_out && !prev_active_reg; // R15
  end

  // Previous corrected sample for edge detection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_active_reg <= 1'b0;
    end else begin
      prev_active_reg <= active_out; // R15
    end
  end

  // Edge mode latches, level mode follows; a new edge beats the vector clear
  always_comb begin
    if (trig_in == EIP_EDGE) begin // R2 R3
      if (rise) begin
        pend_next_out = 1'b1; // R10
      end else if (ack_in) begin
        pend_next_out = 1'b0; // R10
      end else begin
        pend_next_out = pend_in;
      end
    end else begin
      pend_next_out = active_out; // R11 R13
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_edge_sets_flag: assert property ( // R10
    (trig_in && active_out && !prev_active_reg) |-> pend_next_out)
    else $error("Active edge did not set pending");
  a_ack_clears_flag: assert property ( // R10
    (trig_in && ack_in && !(active_out && !prev_active_reg)) |-> !pend_next_out)
    else $error("Vector acknowledge did not clear pending");
  a_level_no_latch: assert property ( // R11
    !trig_in |-> (pend_next_out == active_out))
    else $error("Level pending does not follow input");
  a_edge_holds_flag: assert property ( // R10
    (trig_in && !ack_in && !active_out) |-> (pend_next_out == pend_in))
    else $error("Edge pending changed without cause");
  a_level_rerequest: assert property ( // R13
    (!trig_in && active_out && ack_in) |-> pend_next_out)
    else $error("Held level input not re-requested");
endmodule : eip_input_det
`default_nettype wire

// ==== src/eip_top.sv ====
// External interrupt pin logic: config register, pin sync, pending flags
//
// Functional notes
// R1: Each input has a polarity bit choosing active-high or active-low pin state.
// R2: Each input has a trigger-type bit, from timer control, choosing edge or level.
// R3: Trigger 1 is edge, 0 level; polarity 1 high, 0 low; four combinations.
// R4: Polarity 1 means pin high is active; polarity 0 means pin low is active.
// R5: Three-bit select per input picks port-0 pin 0 through 7.
// R6: Pin choice is independent of the peripheral routing matrix.
// R7: The logic only samples its pin and never disturbs other users of it.
// R8: Software should skip these pins in routing and set them open-drain, latch 1.
// R9: Pending flags sit at timer control bits 1 and 3.
// R10: Edge mode sets pending on active edge, clears when the CPU vectors.
// R11: Level mode pending reads 1 while input active, 0 while inactive, no latch.
// R12: A level source holds its request until the CPU recognises it.
// R13: A level source drops its request before service ends or it re-requests.
// R14: Eight-bit config at 0xE4: second polarity, select, first polarity, select.
// R15: Pins are synchronised and edges found from successive corrected samples.
`timescale 1ns/1ps
`default_nettype none
`include "eip_params.svh"
module eip_top
  import eip_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  input wire logic [7:0] PORT0_PIN_IN,
  input wire logic FIRST_INPUT_TRIGGER_TYPE_IN,
  input wire logic SECOND_INPUT_TRIGGER_TYPE_IN,
  input wire logic FIRST_VECTOR_ACK_IN,
  input wire logic SECOND_VECTOR_ACK_IN,
  output logic FIRST_INPUT_PENDING_OUT,
  output logic SECOND_INPUT_PENDING_OUT,
  output logic [7:0] TIMER_CONTROL_PEND_OUT
);
  logic [7:0] ext_int_pin_config_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [1:0] pend_reg;
  logic [1:0] pend_next;
  logic [1:0] active;
  logic [1:0] trig;
  logic [1:0] ack;
  logic [7:0] rdata_next;
  logic [7:0] timer_ctrl_next;
  logic cfg_hit;

  // Gather the per-input controls into vectors
  always_comb begin
    trig = {SECOND_INPUT_TRIGGER_TYPE_IN, FIRST_INPUT_TRIGGER_TYPE_IN};
    ack = {SECOND_VECTOR_ACK_IN, FIRST_VECTOR_ACK_IN};
    cfg_hit = (SFR_ADDR_IN == `EIP_CFG_ADDR);
  end

  // Configuration register, written at its special-function address
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ext_int_pin_config_reg <= `EIP_CFG_RESET;
    end else if (SFR_WR_IN && cfg_hit) begin
      ext_int_pin_config_reg <= SFR_WDATA_IN; // R14
    end
  end

  // Read data: the register when addressed, zero otherwise
  always_comb begin
    if (SFR_RD_IN && cfg_hit) begin
      rdata_next = ext_int_pin_config_reg; // R14
    end else begin
      rdata_next = `EIP_RDATA_IDLE;
    end
  end

  // Registered read port
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      SFR_RDATA_OUT <= `EIP_RDATA_IDLE;
    end else begin
      SFR_RDATA_OUT <= rdata_next;
    end
  end

  // Two-stage synchroniser on every port-0 pin; input only, nothing driven back
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sync1_reg <= `EIP_SYNC_RESET;
      sync2_reg <= `EIP_SYNC_RESET;
    end else begin
      sync1_reg <= PORT0_PIN_IN; // R7 R15
      sync2_reg <= sync1_reg; // R15
    end
  end

  // One detector per external input, fields at a fixed stride in the config
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_input
      eip_input_det u_det (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .pins_sync_in(sync2_reg),
        .sel_in(ext_int_pin_config_reg[gi*`EIP_FIELD_STRIDE +: `EIP_SEL_WIDTH]), // R5
        .pol_in(ext_int_pin_config_reg[gi*`EIP_FIELD_STRIDE + `EIP_POL_OFS]), // R1
        .trig_in(trig[gi]), // R2
        .ack_in(ack[gi]),
        .pend_in(pend_reg[gi]),
        .active_out(active[gi]),
        .pend_next_out(pend_next[gi])
      );
    end
  endgenerate

  // Place the two flags at their timer control positions
  always_comb begin
    timer_ctrl_next = 8'h00;
    timer_ctrl_next[`EIP_PEND0_BIT] = pend_next[0]; // R9
    timer_ctrl_next[`EIP_PEND1_BIT] = pend_next[1]; // R9
  end

  // Pending flags and their timer control image
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      pend_reg <= 2'h0;
      TIMER_CONTROL_PEND_OUT <= 8'h00;
    end else begin
      pend_reg <= pend_next; // R10 R11
      TIMER_CONTROL_PEND_OUT <= timer_ctrl_next; // R9
    end
  end

  // Separate flag outputs, same flops' next value
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      FIRST_INPUT_PENDING_OUT <= 1'b0;
      SECOND_INPUT_PENDING_OUT <= 1'b0;
    end else begin
      FIRST_INPUT_PENDING_OUT <= pend_next[0];
      SECOND_INPUT_PENDING_OUT <= pend_next[1];
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);

  a_cfg_write_update: assert property ( // R14
    (SFR_WR_IN && SFR_ADDR_IN == `EIP_CFG_ADDR) |=>
      (ext_int_pin_config_reg == $past(SFR_WDATA_IN)))
    else $error("Config write not stored");
  a_cfg_read_back: assert property ( // R14
    (SFR_RD_IN && SFR_ADDR_IN == `EIP_CFG_ADDR) |=>
      (SFR_RDATA_OUT == $past(ext_int_pin_config_reg)))
    else $error("Config read returned wrong value");
  a_cfg_other_addr: assert property ( // R14
    (SFR_ADDR_IN != `EIP_CFG_ADDR) |=>
      (SFR_RDATA_OUT == 8'h00 && $stable(ext_int_pin_config_reg)))
    else $error("Unmapped access had an effect");
  a_timer_ctrl_map: assert property ( // R9
    TIMER_CONTROL_PEND_OUT ==
      {4'h0, SECOND_INPUT_PENDING_OUT, 1'b0, FIRST_INPUT_PENDING_OUT, 1'b0})
    else $error("Pending flags at wrong timer control bits");
  a_first_level_pin: assert property ( // R4
    (!FIRST_INPUT_TRIGGER_TYPE_IN && $stable(PORT0_PIN_IN)
      && $stable(ext_int_pin_config_reg))[*3] |=>
      (FIRST_INPUT_PENDING_OUT == ($past(PORT0_PIN_IN[ext_int_pin_config_reg[2:0]])
        == $past(ext_int_pin_config_reg[3]))))
    else $error("First level flag does not match selected pin");
  a_second_level_pin: assert property ( // R5
    (!SECOND_INPUT_TRIGGER_TYPE_IN && $stable(PORT0_PIN_IN)
      && $stable(ext_int_pin_config_reg))[*3] |=>
      (SECOND_INPUT_PENDING_OUT == ($past(PORT0_PIN_IN[ext_int_pin_config_reg[6:4]])
        == $past(ext_int_pin_config_reg[7]))))
    else $error("Second level flag does not match selected pin");
  a_first_edge_latency: assert property ( // R15
    (FIRST_INPUT_TRIGGER_TYPE_IN && !FIRST_VECTOR_ACK_IN
      && $stable(ext_int_pin_config_reg)
      && ext_int_pin_config_reg[3] && ext_int_pin_config_reg[2:0] == 3'h0
      && !PORT0_PIN_IN[0] ##1 PORT0_PIN_IN[0] ##1 PORT0_PIN_IN[0]
      ##1 FIRST_INPUT_TRIGGER_TYPE_IN && $stable(ext_int_pin_config_reg)) |=>
      FIRST_INPUT_PENDING_OUT)
    else $error("Rising edge on pin 0 not flagged in time");
  a_first_ack_clear: assert property ( // R10
    (FIRST_INPUT_TRIGGER_TYPE_IN && FIRST_VECTOR_ACK_IN
      && !(active[0] && !$past(active[0]))) |=> !FIRST_INPUT_PENDING_OUT)
    else $error("Vectoring did not clear edge flag");
  a_edge_flag_holds: assert property ( // R10
    (FIRST_INPUT_TRIGGER_TYPE_IN && !FIRST_VECTOR_ACK_IN && FIRST_INPUT_PENDING_OUT)
      |=> FIRST_INPUT_PENDING_OUT)
    else $error("Edge flag dropped without vectoring");
  a_level_follows: assert property ( // R11
    !SECOND_INPUT_TRIGGER_TYPE_IN |=> (SECOND_INPUT_PENDING_OUT == $past(active[1])))
    else $error("Level flag latched or lagged");

  // First input level flag follows its corrected pin with one register stage
  a_first_level_follows: assert property ( // R11
    !FIRST_INPUT_TRIGGER_TYPE_IN |=> (FIRST_INPUT_PENDING_OUT == $past(active[0])))
    else $error("First level flag latched or lagged");

  // Edge mode: a fresh active sample sets the flag, vectoring wins only without it
  a_first_edge_set: assert property ( // R10
    (FIRST_INPUT_TRIGGER_TYPE_IN && active[0] && !$past(active[0]))
      |=> FIRST_INPUT_PENDING_OUT)
    else $error("First active edge not flagged");
  a_second_ack_clear: assert property ( // R10
    (SECOND_INPUT_TRIGGER_TYPE_IN && SECOND_VECTOR_ACK_IN
      && !(active[1] && !$past(active[1]))) |=> !SECOND_INPUT_PENDING_OUT)
    else $error("Vectoring did not clear second edge flag");
  a_second_flag_holds: assert property ( // R10
    (SECOND_INPUT_TRIGGER_TYPE_IN && !SECOND_VECTOR_ACK_IN && SECOND_INPUT_PENDING_OUT)
      |=> SECOND_INPUT_PENDING_OUT)
    else $error("Second edge flag dropped without vectoring");

  // Read data returns to idle whenever no read is made
  a_rdata_idle: assert property ( // R14
    !SFR_RD_IN |=> (SFR_RDATA_OUT == `EIP_RDATA_IDLE))
    else $error("Read data not idle without a read");

  // Reset edge leaves every output and the config at its reset value
  a_reset_state: assert property (@(posedge CLK_SYS_IN) disable iff (1'b0) // R14
    SRST_IN |=> (ext_int_pin_config_reg == `EIP_CFG_RESET
      && SFR_RDATA_OUT == `EIP_RDATA_IDLE && TIMER_CONTROL_PEND_OUT == 8'h00
      && !FIRST_INPUT_PENDING_OUT && !SECOND_INPUT_PENDING_OUT))
    else $error("Reset did not restore outputs and config");
endmodule : eip_top
`default_nettype wire

// ==== sim/eip_src_model.sv ====
// Model of the external interrupt sources that drive the port-0 pins
`timescale 1ns/1ps
`default_nettype none
module eip_src_model (
  input wire logic clk_in,
  output logic [7:0] pins_out
);
  // Pins are open-drain with latch 1, so they idle high until a source pulls
  initial pins_out = 8'hFF;
  // A source holds the level it was given until it is told to withdraw it
  task automatic put(input logic [7:0] v);
    @(negedge clk_in);
    pins_out = v;
  endtask : put
endmodule : eip_src_model
`default_nettype wire

// ==== sim/tb_eip_top.sv ====
// Self-checking bench for the external interrupt pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_eip_top;
  logic clk = 0, srst = 1, wr = 0, rd = 0, t0 = 0, t1 = 0, ak0 = 0, ak1 = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, tmr_ctl, pins;
  logic p0, p1, rd_d;
  logic [7:0] rd_q[$];
  logic [9:0] st_q[$];
  int err_count = 0, num_checks = 0, cyc = 0;
  // 50 MHz system clock
  always #10 clk = ~clk;
  eip_src_model u_src (.clk_in(clk), .pins_out(pins));
  eip_top u_dut (.CLK_SYS_IN(clk), .SRST_IN(srst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_WDATA_IN(wd), .SFR_RDATA_OUT(rdata), .PORT0_PIN_IN(pins),
    .FIRST_INPUT_TRIGGER_TYPE_IN(t0), .SECOND_INPUT_TRIGGER_TYPE_IN(t1),
    .FIRST_VECTOR_ACK_IN(ak0), .SECOND_VECTOR_ACK_IN(ak1),
    .FIRST_INPUT_PENDING_OUT(p0), .SECOND_INPUT_PENDING_OUT(p1),
    .TIMER_CONTROL_PEND_OUT(tmr_ctl));
  // Compares a seen value with the expected one and counts both
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Prints the verdict and stops the run
  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // One register cycle from a falling edge; for a read d is the expected data
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    if (!w) rd_q.push_back(d);
    @(negedge clk);
  endtask : sfr
  // Lets the pin change cross the synchroniser, notes both flags, waits for the compare
  task automatic expect_st(input logic a, input logic b);
    repeat (3) @(negedge clk);
    st_q.push_back({4'h0, b, 1'b0, a, 1'b0, b, a});
    @(negedge clk);
  endtask : expect_st
  // Monitor: after each rising edge, matches read data and flag notes in order
  always @(posedge clk) begin
    rd_d = rd;
    #2;
    if (rd_d && rd_q.size() > 0) check("rdata", {2'b00, rdata}, {2'b00, rd_q.pop_front()});
    if (st_q.size() > 0) check("pending", {tmr_ctl, p1, p0}, st_q.pop_front());
  end
  // Watchdog against a hung run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Main sequence: register access, then every mode, polarity and pin select
  initial begin
    logic [7:0] v, c;
    void'($urandom(76));
    repeat (12) @(negedge clk);
    srst = 0;
    sfr(0, 8'hE4, 8'h01);
    sfr(0, 8'hE5, 8'h00);
    c = $urandom;
    sfr(1, 8'hE4, c);
    sfr(0, 8'hE4, c);
    sfr(1, 8'hE5, ~c);
    sfr(0, 8'hE4, c);
    for (int t = 0; t < 2; t++) begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < 8; s++) begin
          {t0, t1} = 2'b00;
          sfr(1, 8'hE4, {p[0], s[2:0], p[0], s[2:0]});
          wr = 0;
          v = $urandom;
          v[s] = !p[0];
          u_src.put(v);
          expect_st(0, 0);
          {t0, t1} = {t[0], t[0]};
          v = $urandom;
          v[s] = p[0];
          u_src.put(v);
          expect_st(1, 1);
          v = $urandom;
          v[s] = !p[0];
          u_src.put(v);
          expect_st(t[0], t[0]);
          if (t == 1) begin
            ak0 = 1;
            @(negedge clk);
            ak0 = 0;
            expect_st(0, 1);
            ak1 = 1;
            @(negedge clk);
            ak1 = 0;
            expect_st(0, 0);
          end
        end
      end
    end
    // Mid-run reset with both edge flags set, then reset state with idle pins
    v = $urandom;
    v[7] = 1'b1;
    u_src.put(v);
    expect_st(1, 1);
    srst = 1;
    u_src.put(8'hFF);
    repeat (2) @(negedge clk);
    srst = 0;
    st_q.push_back(10'h000);
    sfr(0, 8'hE4, 8'h01);
    rd = 0;
    expect_st(0, 0);
    repeat (3) @(negedge clk);
    tally_and_finish();
  end
endmodule : tb_eip_top
`default_nettype wire
